// ===== verilog/readout_pkg.sv
// Constants and types for the converter serial readout block.
// Assumes a 25 MHz system clock; all times scale from a 4.9152 MHz converter clock.
// Summary of operation
// - Pin goes low when new result ready
// - First rising clock edge presents MSB
// - Each further rising edge shifts next bit
// - Edge 21 forces pin high until next
// - Edges 21 to 24 output ones
// - After 20 clocks hold last bit till update
// - Convert continuously, new result every period
// - Edge 25 keeps high; fall 26 calibrates
// - Calibration disconnects inputs, applies own signal
// - Ready after calibration time, settled result
// - Clock high 20 us enters standby
// - Standby from conversion or calibration, not wake; pin stays high
// - First result after wake ready time
// - Durations scale with converter clock period; here fixed counts for the nominal 4.9152 MHz
// - Twos complement, clipped at full scale
// - Rate select low 10, high 80 per second
package readout_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RESULT_BITS = 20;
  localparam logic [4:0] EDGE_LAST_BIT = 5'd20;
  localparam logic [4:0] EDGE_PAD_LAST = 5'd24;
  localparam logic [4:0] EDGE_CAL_REQ = 5'd26;
  // Times in microseconds, nominal converter clock 4.9152 MHz
  localparam int unsigned CONV_US_FAST = 12_500;
  localparam int unsigned CONV_US_SLOW = 100_000;
  localparam int unsigned UPDATE_US = 39;
  localparam int unsigned STANDBY_US = 20;
  localparam int unsigned CAL_US_FAST = 101_280;
  localparam int unsigned CAL_US_SLOW = 801_020;
  localparam int unsigned WAKE_US_FAST = 52_510;
  localparam int unsigned WAKE_US_SLOW = 401_800;
  // Cycle counts: least times round up
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned UPDATE_CYC = UPDATE_US * CYC_PER_US;
  localparam int unsigned STANDBY_CYC = STANDBY_US * CYC_PER_US;
  localparam int unsigned CONV_CYC_FAST = CONV_US_FAST * CYC_PER_US;
  localparam int unsigned CONV_CYC_SLOW = CONV_US_SLOW * CYC_PER_US;
  localparam int unsigned CAL_CYC_FAST = CAL_US_FAST * CYC_PER_US;
  localparam int unsigned CAL_CYC_SLOW = CAL_US_SLOW * CYC_PER_US;
  localparam int unsigned WAKE_CYC_FAST = WAKE_US_FAST * CYC_PER_US;
  localparam int unsigned WAKE_CYC_SLOW = WAKE_US_SLOW * CYC_PER_US;
  localparam logic [19:0] CODE_POS_FS = 20'h7ffff;
  localparam logic [19:0] CODE_NEG_FS = 20'h80000;

  typedef enum logic [1:0] {
    ST_CONVERT = 2'b00,
    ST_CALIBRATE = 2'b01,
    ST_STANDBY = 2'b10,
    ST_WAKE = 2'b11
  } mode_e;

  // Analog-side control bundle
  typedef struct packed {
    logic inputs_disconnected;
    logic cal_signal_applied;
    logic analog_powered;
  } analog_ctrl_s;
endpackage

// ===== verilog/adc_readout.sv
// Serial readout, calibration and standby control of the converter.
// Assumes shift clock and rate select arrive asynchronously; sample comes from the filter.
`timescale 1ns/1ps
module adc_readout #(
  parameter int unsigned CONV_FAST = readout_pkg::CONV_CYC_FAST,
  parameter int unsigned CONV_SLOW = readout_pkg::CONV_CYC_SLOW,
  parameter int unsigned CAL_FAST = readout_pkg::CAL_CYC_FAST,
  parameter int unsigned CAL_SLOW = readout_pkg::CAL_CYC_SLOW,
  parameter int unsigned WAKE_FAST = readout_pkg::WAKE_CYC_FAST,
  parameter int unsigned WAKE_SLOW = readout_pkg::WAKE_CYC_SLOW
) (
  // System
  input wire logic clock,
  input wire logic srst,
  // Host link
  input wire logic shift_clock,
  input wire logic rate_select,
  output logic ready_data_out,
  // Filter side: raw signed result, wider to allow clipping
  input wire logic signed [23:0] filter_sample,
  // Analog control
  output readout_pkg::analog_ctrl_s analog_ctrl,
  output readout_pkg::mode_e mode
);
  import readout_pkg::*;

  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic rate_s1_q, rate_s2_q;
  logic rise, fall;
  logic [31:0] conv_cnt_q, mode_cnt_q, hi_cnt_q;
  logic [19:0] result_q, shift_q;
  logic [4:0] edge_cnt_q;
  logic ready_q, reading_q, updating_q;
  logic conv_done;
  logic [31:0] conv_len, cal_len, wake_len;

  // Clip to full-scale codes
  function automatic logic [19:0] clip(input logic signed [23:0] s);
    if (s > $signed({4'h0, CODE_POS_FS})) begin
      clip = CODE_POS_FS;
    end else if (s < $signed({4'hf, CODE_NEG_FS})) begin
      clip = CODE_NEG_FS;
    end else begin
      clip = s[19:0];
    end
  endfunction

  // Two-flop synchronisers, third stage only for edges
  always_ff @(posedge clock) begin
    if (srst) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      rate_s1_q <= 1'b0;
      rate_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= shift_clock;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      rate_s1_q <= rate_select;
      rate_s2_q <= rate_s1_q;
    end
  end
  assign rise = sclk_s2_q & ~sclk_s3_q;
  assign fall = ~sclk_s2_q & sclk_s3_q;

  // Rate select picks period lengths; counts are fixed for the nominal converter clock
  assign conv_len = rate_s2_q ? CONV_FAST : CONV_SLOW;
  assign cal_len = rate_s2_q ? CAL_FAST : CAL_SLOW;
  assign wake_len = rate_s2_q ? WAKE_FAST : WAKE_SLOW;

  // Free-running conversion period while converting
  always_ff @(posedge clock) begin
    if (srst || mode != ST_CONVERT) begin
      conv_cnt_q <= 32'h0;
    end else if (conv_cnt_q >= conv_len - 32'h1) begin
      conv_cnt_q <= 32'h0;
    end else begin
      conv_cnt_q <= conv_cnt_q + 32'h1;
    end
  end

  // Result ready at period end, after calibration or after wake-up
  assign conv_done = (mode == ST_CONVERT && conv_cnt_q >= conv_len - 32'h1) ||
    (mode != ST_CONVERT && mode != ST_STANDBY && mode_cnt_q >= wake_len - 32'h1 && mode == ST_WAKE) ||
    (mode == ST_CALIBRATE && mode_cnt_q >= cal_len - 32'h1);

  // Update window precedes each periodic result while converting, not calibration or wake results; pin forced high inside it
  // Only a flag is kept: the conversion counter already marks the window's start
  always_ff @(posedge clock) begin
    if (srst) begin
      updating_q <= 1'b0;
    end else if (mode == ST_CONVERT && conv_cnt_q == conv_len - 32'h1 - UPDATE_CYC) begin
      updating_q <= 1'b1;
    end else if (conv_done) begin
      updating_q <= 1'b0;
    end
  end

  // Shift clock high time for standby detection
  always_ff @(posedge clock) begin
    if (srst || !sclk_s2_q) begin
      hi_cnt_q <= 32'h0;
    end else if (hi_cnt_q < STANDBY_CYC) begin
      hi_cnt_q <= hi_cnt_q + 32'h1;
    end
  end

  // Mode sequencing: calibration, standby, wake
  always_ff @(posedge clock) begin
    if (srst) begin
      mode <= ST_CONVERT;
      mode_cnt_q <= 32'h0;
    end else begin
      case (mode)
        ST_CONVERT: begin
          mode_cnt_q <= 32'h0;
          if (hi_cnt_q == STANDBY_CYC) begin
            mode <= ST_STANDBY;
          end else if (fall && edge_cnt_q >= EDGE_CAL_REQ) begin
            mode <= ST_CALIBRATE;
          end
        end
        ST_CALIBRATE: begin
          if (hi_cnt_q == STANDBY_CYC) begin
            mode <= ST_STANDBY;
            mode_cnt_q <= 32'h0;
          end else if (conv_done) begin
            mode <= ST_CONVERT;
          end else begin
            mode_cnt_q <= mode_cnt_q + 32'h1;
          end
        end
        ST_STANDBY: begin
          mode_cnt_q <= 32'h0;
          if (!sclk_s2_q) begin
            mode <= ST_WAKE;
          end
        end
        default: begin
          if (conv_done) begin
            mode <= ST_CONVERT;
          end else begin
            mode_cnt_q <= mode_cnt_q + 32'h1;
          end
        end
      endcase
    end
  end

  // Analog controls follow the mode
  always_ff @(posedge clock) begin
    if (srst) begin
      analog_ctrl <= '{inputs_disconnected: 1'b0, cal_signal_applied: 1'b0, analog_powered: 1'b1};
    end else begin
      analog_ctrl.inputs_disconnected <= (mode == ST_CALIBRATE);
      analog_ctrl.cal_signal_applied <= (mode == ST_CALIBRATE);
      analog_ctrl.analog_powered <= (mode != ST_STANDBY);
    end
  end

  // Latch result and count shift edges; a new result restarts the read
  always_ff @(posedge clock) begin
    if (srst) begin
      result_q <= 20'h0;
      shift_q <= 20'h0;
      edge_cnt_q <= 5'd0;
      ready_q <= 1'b0;
      reading_q <= 1'b0;
    end else if (conv_done) begin
      result_q <= clip(filter_sample);
      shift_q <= clip(filter_sample);
      edge_cnt_q <= 5'd0;
      ready_q <= 1'b1;
      reading_q <= 1'b0;
    end else if (mode == ST_STANDBY || updating_q) begin
      ready_q <= 1'b0;
      reading_q <= 1'b0;
    end else if (rise && edge_cnt_q != 5'h1f) begin
      edge_cnt_q <= edge_cnt_q + 5'd1;
      reading_q <= 1'b1;
      if (edge_cnt_q != 5'd0) begin
        shift_q <= {shift_q[18:0], 1'b1};
      end
      if (edge_cnt_q >= EDGE_LAST_BIT) begin
        ready_q <= 1'b0;
      end
    end
  end

  // Pin: low when ready, then data, high once padded or idle
  always_ff @(posedge clock) begin
    if (srst) begin
      ready_data_out <= 1'b1;
    end else if (mode == ST_STANDBY || updating_q) begin
      ready_data_out <= 1'b1;
    end else if (reading_q && edge_cnt_q <= EDGE_LAST_BIT) begin
      ready_data_out <= shift_q[19];
    end else if (reading_q) begin
      ready_data_out <= 1'b1;
    end else begin
      ready_data_out <= ~ready_q;
    end
  end

  // Standby entry needs the shift clock high for the activation time
  standby_entry_a: assert property (@(posedge clock) disable iff (srst)
    (mode == ST_CONVERT && hi_cnt_q == STANDBY_CYC) |=> mode == ST_STANDBY)
    else $error("standby not entered");

  // Pin stays high in standby
  standby_high_a: assert property (@(posedge clock) disable iff (srst)
    (mode == ST_STANDBY) |=> ##1 ready_data_out || mode != ST_STANDBY)
    else $error("pin low in standby");

  // New result pulls the pin low
  ready_low_a: assert property (@(posedge clock) disable iff (srst)
    (conv_done && mode == ST_CONVERT && hi_cnt_q != STANDBY_CYC) |=> ##1 !ready_data_out || rise)
    else $error("ready not shown");

  // MSB presented on first rising edge
  sequence first_edge_s;
    rise && edge_cnt_q == 5'd0 && ready_q && !updating_q && !conv_done && mode == ST_CONVERT;
  endsequence
  msb_first_a: assert property (@(posedge clock) disable iff (srst)
    first_edge_s |=> ##1 (ready_data_out == result_q[19] || updating_q || mode != ST_CONVERT))
    else $error("msb not presented");

  // Padding edges force pin high
  pad_high_a: assert property (@(posedge clock) disable iff (srst)
    (reading_q && edge_cnt_q > EDGE_LAST_BIT && !conv_done) |=> ready_data_out)
    else $error("pad not high");

  // Falling edge after 26 clocks starts calibration
  cal_start_a: assert property (@(posedge clock) disable iff (srst)
    (mode == ST_CONVERT && fall && edge_cnt_q >= EDGE_CAL_REQ && hi_cnt_q != STANDBY_CYC)
    |=> mode == ST_CALIBRATE)
    else $error("calibration not started");

  // Inputs disconnected while calibrating
  cal_disc_a: assert property (@(posedge clock) disable iff (srst)
    (mode == ST_CALIBRATE) [*2] |-> analog_ctrl.inputs_disconnected)
    else $error("inputs not disconnected");

  // Wake leads back to conversion after wake time
  wake_end_a: assert property (@(posedge clock) disable iff (srst)
    (mode == ST_WAKE && mode_cnt_q >= wake_len - 32'h1) |=> mode == ST_CONVERT)
    else $error("wake too long");
endmodule

// ===== verification/host_model.sv
// Host side of the readout link: clocks the shift pin and samples the data pin.
// Assumes the device synchronises shift_clock itself; link period 320 ns.
`timescale 1ns/1ps
module host_model (
  // Link
  output logic shift_clock,
  input wire logic ready_data_out
);
  // Idles low between frames, so no stray edge reaches the device
  initial shift_clock = 1'b0;
  // Clock n pulses; sample late in the low half, before the next rise
  task automatic pulses(input int n, output logic [31:0] bits);
    bits = '0;
    for (int i = 0; i < n; i++) begin
      shift_clock = 1'b1;
      #160;
      shift_clock = 1'b0;
      #150;
      bits = {bits[30:0], ready_data_out};
      #10;
    end
  endtask
  // Standby request: level held high until wake
  task automatic hold_high();
    shift_clock = 1'b1;
  endtask
  task automatic release_low();
    shift_clock = 1'b0;
  endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the converter readout block, driven by a host model.
// Assumes shortened period, calibration and wake counts set below.
`timescale 1ns/1ps
module tb_top;
  import readout_pkg::*;
  localparam int CF = 2000;
  localparam int CS = 2400;
  localparam int CALF = 3000;
  localparam int WF = 2500;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic rate_select = 1'b1;
  logic signed [23:0] filter_sample = 24'sh012345;
  logic shift_clock;
  logic ready_data_out;
  analog_ctrl_s analog_ctrl;
  mode_e mode;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] bits;
  int n;
  always #20 clock = ~clock;
  adc_readout #(.CONV_FAST(CF), .CONV_SLOW(CS), .CAL_FAST(CALF), .CAL_SLOW(3400), .WAKE_FAST(WF),
    .WAKE_SLOW(2800)) dut (.clock(clock), .srst(srst), .shift_clock(shift_clock), .rate_select(rate_select),
    .ready_data_out(ready_data_out), .filter_sample(filter_sample), .analog_ctrl(analog_ctrl), .mode(mode));
  host_model host (.shift_clock(shift_clock), .ready_data_out(ready_data_out));
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Cycle counts carry synchroniser slack, so allow a tolerance
  task automatic near(input int got, input int exp, input int tol);
    chk(32'(got), (got >= exp - tol && got <= exp + tol) ? 32'(got) : 32'(exp));
  endtask
  // Steps k clocks and settles just after the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // Bounded wait for the pin to reach a level
  task automatic wait_pin(input logic lvl, inout int cnt);
    while (ready_data_out !== lvl) begin
      cyc(1);
      cnt++;
      if (cnt > 8000) begin
        chk(ready_data_out, lvl);
        results();
      end
    end
  endtask
  // Pin high first, so the result seen is a fresh one
  task automatic wait_ready(output int cnt);
    cnt = 0;
    wait_pin(1'b1, cnt);
    wait_pin(1'b0, cnt);
  endtask
  task automatic set_sample(input logic [23:0] v);
    cyc(1);
    filter_sample = v;
  endtask
  task automatic t_read();
    wait_ready(n);
    host.pulses(24, bits);
    chk(bits, 32'h12345f);
    $display("test read done");
  endtask
  task automatic t_clip();
    set_sample(24'sh400000);
    wait_ready(n);
    host.pulses(20, bits);
    chk(bits, 32'h7ffff);
    set_sample(24'shc00000);
    wait_ready(n);
    host.pulses(20, bits);
    chk(bits, 32'h80000);
    cyc(500);
    chk(ready_data_out, 1'b0);
    wait_ready(n);
    $display("test clip done");
  endtask
  task automatic t_force();
    set_sample(24'sh000000);
    wait_ready(n);
    host.pulses(21, bits);
    chk(bits, 32'h1);
    cyc(500);
    chk(ready_data_out, 1'b1);
    $display("test force done");
  endtask
  task automatic t_rate();
    for (int r = 0; r < 2; r++) begin
      cyc(1);
      rate_select = r[0];
      wait_ready(n);
      wait_ready(n);
      near(n, r ? CF : CS, 4);
    end
    $display("test rate done");
  endtask
  task automatic t_cal();
    wait_ready(n);
    host.pulses(26, bits);
    chk(bits, 32'h3f);
    cyc(10);
    chk(mode, ST_CALIBRATE);
    chk({analog_ctrl.inputs_disconnected, analog_ctrl.cal_signal_applied}, 2'b11);
    wait_ready(n);
    near(n, CALF - 14, 8);
    $display("test cal done");
  endtask
  task automatic t_stby();
    wait_ready(n);
    host.pulses(5, bits);
    host.hold_high();
    cyc(400);
    chk(mode, ST_CONVERT);
    cyc(200);
    chk(mode, ST_STANDBY);
    chk({analog_ctrl.analog_powered, ready_data_out}, 2'b01);
    host.release_low();
    cyc(10);
    chk(mode, ST_WAKE);
    wait_ready(n);
    near(n, WF - 10, 8);
    $display("test standby done");
  endtask
  initial begin
    cyc(3);
    srst = 1'b0;
    t_read();
    t_clip();
    t_force();
    t_rate();
    t_cal();
    t_stby();
    results();
  end
endmodule
